// ==== brake_seq_model.sv ====
`timescale 1ns/1ps
// Lift brake sequencer on the far side that reads the over-torque output of the drive.
module brake_seq_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic arrival,
  input wire logic over_torque,
  output logic braking
);
  // Braking starts on arrival and ends on over-torque, which wins when both coincide.
  always_ff @(posedge clk) begin
    if (rst) begin
      braking <= 1'b0;
    end else if (over_torque) begin
      braking <= 1'b0;
    end else if (arrival) begin
      braking <= 1'b1;
    end
  end
endmodule

// ==== drive_status_flag_outputs.sv ====
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Contract
// R1: Over-torque flag high while estimated torque exceeds the torque threshold.
// R2: Over-torque flag only meaningful in sensorless vector mode; held low otherwise.
// R3: Low supply flag follows the undervoltage condition.
// R4: Torque-limit flag follows torque limiting operation.
// R5: Run-time flag high once accumulated running time exceeds the time limit.
// R6: Powered-time flag high once accumulated powered time exceeds the same limit.
// R7: Thermal warning flag high while thermal level exceeds the warning level.
// R8: Any flag may be routed to output 11, output 12 or the relay.
// R9: Lift controllers end braking on over-torque and begin it on frequency arrival.
// R10: Each output carries its selected flag, re-evaluated every control cycle.
module drive_status_flag_outputs #(
  parameter logic [63:0] TIME_UNIT_CYCLES = flag_out_pkg::TIME_UNIT_CYCLES,
  parameter int LEVEL_W = 16
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [LEVEL_W-1:0] TORQUE_EST,
  input wire logic UNDERVOLT,
  input wire logic TORQUE_LIMITING,
  input wire logic MOTOR_RUNNING,
  input wire logic [LEVEL_W-1:0] THERMAL_LEVEL,
  output logic OUT11,
  output logic OUT12,
  output logic RELAY,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the block.
  typedef struct packed {
    logic [7:0] sel11;
    logic [7:0] sel12;
    logic [7:0] selr;
    logic [7:0] vf;
    logic [LEVEL_W-1:0] torque_thr;
    logic [15:0] time_lim;
    logic [LEVEL_W-1:0] warn_lvl;
    logic [flag_out_pkg::NUM_FLAGS-1:0] flags;
    logic [flag_out_pkg::NUM_FLAGS-1:0] irq_sts;
    logic [flag_out_pkg::NUM_FLAGS-1:0] irq_mask;
    flag_out_pkg::bus_state_t bst;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic irq;
    logic out11;
    logic out12;
    logic relay;
  } state_t;

  localparam state_t ST_RST = '{
    sel11: flag_out_pkg::SEL_RST,
    sel12: flag_out_pkg::SEL_RST,
    selr: flag_out_pkg::SEL_RST,
    vf: flag_out_pkg::VF_RST,
    torque_thr: LEVEL_W'(flag_out_pkg::TORQUE_THR_RST),
    time_lim: flag_out_pkg::TIME_LIM_RST,
    warn_lvl: LEVEL_W'(flag_out_pkg::WARN_LVL_RST),
    flags: '0,
    irq_sts: '0,
    irq_mask: flag_out_pkg::MASK_RST,
    bst: flag_out_pkg::BUS_IDLE,
    addr: 8'h00,
    rdata: 32'h00000000,
    ready: 1'b1,
    resp: 1'b0,
    irq: 1'b0,
    out11: 1'b0,
    out12: 1'b0,
    relay: 1'b0
  };

  state_t st_reg;
  state_t st_next;
  logic [15:0] run_hours;
  logic [15:0] pwr_hours;
  logic [flag_out_pkg::NUM_FLAGS-1:0] flags_now;
  logic accept;

  flag_sel_if fsel();

  ////////////////////////////////////////////////////////////////////////////
  // Accumulated running time and accumulated powered time.
  hour_accum #(.UNIT_CYCLES(TIME_UNIT_CYCLES), .WIDTH(16)) u_run (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .ce(CE),
    .en(MOTOR_RUNNING),
    .units(run_hours)
  );

  hour_accum #(.UNIT_CYCLES(TIME_UNIT_CYCLES), .WIDTH(16)) u_pwr (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .ce(CE),
    .en(1'b1),
    .units(pwr_hours)
  );

  // The router picks each output's flag from the registered flag set.
  assign fsel.flags = st_reg.flags;
  assign fsel.sel[0] = st_reg.sel11;
  assign fsel.sel[1] = st_reg.sel12;
  assign fsel.sel[2] = st_reg.selr;

  flag_route u_route (
    .rt(fsel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flag comparisons, evaluated fresh from the inputs every cycle.
  always_comb begin
    flags_now = '0;
    flags_now[flag_out_pkg::FLG_OVER_TORQUE] = (st_reg.vf == flag_out_pkg::VF_SENSORLESS_VECTOR) // R2
                                              && (TORQUE_EST > st_reg.torque_thr); // R1
    flags_now[flag_out_pkg::FLG_LOW] = UNDERVOLT; // R3
    flags_now[flag_out_pkg::FLG_TLIM] = TORQUE_LIMITING; // R4
    flags_now[flag_out_pkg::FLG_RUN] = run_hours > st_reg.time_lim; // R5
    flags_now[flag_out_pkg::FLG_PWR] = pwr_hours > st_reg.time_lim; // R6
    flags_now[flag_out_pkg::FLG_THERMAL] = THERMAL_LEVEL > st_reg.warn_lvl; // R7
  end

  // Returns the word a read of the given offset shows.
  function automatic logic [31:0] read_word(input logic [7:0] a, input state_t s,
                                            input logic [15:0] rh, input logic [15:0] ph);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      flag_out_pkg::OFS_SEL: w = {8'h00, s.selr, s.sel12, s.sel11};
      flag_out_pkg::OFS_VF: w[7:0] = s.vf;
      flag_out_pkg::OFS_TORQUE_THR: w[LEVEL_W-1:0] = s.torque_thr;
      flag_out_pkg::OFS_TIME_LIM: w[15:0] = s.time_lim;
      flag_out_pkg::OFS_WARN_LVL: w[LEVEL_W-1:0] = s.warn_lvl;
      flag_out_pkg::OFS_FLAGS: w = {21'h0, s.relay, s.out12, s.out11, 2'h0, s.flags};
      flag_out_pkg::OFS_RUN_HRS: w[15:0] = rh;
      flag_out_pkg::OFS_PWR_HRS: w[15:0] = ph;
      flag_out_pkg::OFS_IRQ_STS: w[flag_out_pkg::NUM_FLAGS-1:0] = s.irq_sts;
      flag_out_pkg::OFS_IRQ_MASK: w[flag_out_pkg::NUM_FLAGS-1:0] = s.irq_mask;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  assign accept = HSEL && HREADY && HTRANS[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, register writes, flags, interrupts and outputs.
  always_comb begin
    logic rd_now;
    logic [7:0] rd_addr;
    logic [flag_out_pkg::NUM_FLAGS-1:0] sts;
    rd_now = 1'b0;
    rd_addr = 8'h00;
    sts = st_reg.irq_sts;
    st_next = st_reg;
    if (CE) begin
      // Bus phases; a read that meets a pending write waits one cycle.
      case (st_reg.bst)
        flag_out_pkg::BUS_IDLE: begin
          if (accept && HWRITE) begin
            st_next.addr = {HADDR[7:2], 2'b00};
            st_next.bst = flag_out_pkg::BUS_WDATA;
          end else if (accept) begin
            rd_now = 1'b1;
            rd_addr = {HADDR[7:2], 2'b00};
          end
        end
        flag_out_pkg::BUS_WDATA: begin
          case (st_reg.addr)
            flag_out_pkg::OFS_SEL: begin
              st_next.sel11 = HWDATA[flag_out_pkg::SEL11_LSB +: 8]; // R8
              st_next.sel12 = HWDATA[flag_out_pkg::SEL12_LSB +: 8]; // R8
              st_next.selr = HWDATA[flag_out_pkg::SELR_LSB +: 8]; // R8
            end
            flag_out_pkg::OFS_VF: st_next.vf = HWDATA[7:0];
            flag_out_pkg::OFS_TORQUE_THR: st_next.torque_thr = HWDATA[LEVEL_W-1:0];
            flag_out_pkg::OFS_TIME_LIM: st_next.time_lim = HWDATA[15:0];
            flag_out_pkg::OFS_WARN_LVL: st_next.warn_lvl = HWDATA[LEVEL_W-1:0];
            flag_out_pkg::OFS_IRQ_MASK: st_next.irq_mask = HWDATA[flag_out_pkg::NUM_FLAGS-1:0];
            default: st_next.addr = st_reg.addr;
          endcase
          if (accept && HWRITE) begin
            st_next.addr = {HADDR[7:2], 2'b00};
          end else if (accept) begin
            st_next.addr = {HADDR[7:2], 2'b00};
            st_next.ready = 1'b0;
            st_next.bst = flag_out_pkg::BUS_RWAIT;
          end else begin
            st_next.bst = flag_out_pkg::BUS_IDLE;
          end
        end
        flag_out_pkg::BUS_RWAIT: begin
          rd_now = 1'b1;
          rd_addr = st_reg.addr;
          st_next.ready = 1'b1;
          st_next.bst = flag_out_pkg::BUS_IDLE;
        end
        default: begin
          st_next.ready = 1'b1;
          st_next.bst = flag_out_pkg::BUS_IDLE;
        end
      endcase
      if (rd_now) begin
        st_next.rdata = read_word(rd_addr, st_reg, run_hours, pwr_hours);
        if (rd_addr == flag_out_pkg::OFS_IRQ_STS) begin
          sts = '0;
        end
      end
      st_next.resp = 1'b0;
      // Flags and routed outputs are refreshed every enabled cycle.
      st_next.flags = flags_now; // R10
      st_next.out11 = fsel.level[0]; // R8 R10
      st_next.out12 = fsel.level[1]; // R8 R10
      st_next.relay = fsel.level[2]; // R8 R10
      // A rising flag sets its sticky bit; the set wins over a read clear.
      st_next.irq_sts = sts | (flags_now & ~st_reg.flags);
      st_next.irq = |(st_next.irq_sts & st_next.irq_mask);
    end
  end

  // Registers the whole state; reset is synchronous.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output comes straight from the state register.
  assign HRDATA = st_reg.rdata;
  assign HREADYOUT = st_reg.ready;
  assign HRESP = st_reg.resp;
  assign OUT11 = st_reg.out11;
  assign OUT12 = st_reg.out12;
  assign RELAY = st_reg.relay;
  assign IRQ = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the flag logic, the routing, the interrupt, clock enable and the bus stall.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_over_torque_set;
    (CE && st_reg.vf == flag_out_pkg::VF_SENSORLESS_VECTOR && TORQUE_EST > st_reg.torque_thr)
      |=> st_reg.flags[flag_out_pkg::FLG_OVER_TORQUE];
  endproperty
  a_over_torque_set: assert property (p_over_torque_set) else $error("over-torque flag missing"); // R1

  property p_over_torque_clear;
    (CE && TORQUE_EST <= st_reg.torque_thr) |=> !st_reg.flags[flag_out_pkg::FLG_OVER_TORQUE];
  endproperty
  a_over_torque_clear: assert property (p_over_torque_clear) else $error("over-torque flag stuck"); // R1

  property p_over_torque_mode;
    (CE && st_reg.vf != flag_out_pkg::VF_SENSORLESS_VECTOR) |=> !st_reg.flags[flag_out_pkg::FLG_OVER_TORQUE];
  endproperty
  a_over_torque_mode: assert property (p_over_torque_mode) else $error("over-torque flag outside vector mode"); // R2

  property p_low_supply;
    CE |=> st_reg.flags[flag_out_pkg::FLG_LOW] == $past(UNDERVOLT);
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("low supply flag wrong"); // R3

  property p_torque_limit;
    CE |=> st_reg.flags[flag_out_pkg::FLG_TLIM] == $past(TORQUE_LIMITING);
  endproperty
  a_torque_limit: assert property (p_torque_limit) else $error("torque limit flag wrong"); // R4

  property p_run_time;
    CE |=> st_reg.flags[flag_out_pkg::FLG_RUN] == ($past(run_hours) > $past(st_reg.time_lim));
  endproperty
  a_run_time: assert property (p_run_time) else $error("run time flag wrong"); // R5

  property p_pwr_time;
    CE |=> st_reg.flags[flag_out_pkg::FLG_PWR] == ($past(pwr_hours) > $past(st_reg.time_lim));
  endproperty
  a_pwr_time: assert property (p_pwr_time) else $error("powered time flag wrong"); // R6

  property p_thermal;
    CE |=> st_reg.flags[flag_out_pkg::FLG_THERMAL] == ($past(THERMAL_LEVEL) > $past(st_reg.warn_lvl));
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal warning flag wrong"); // R7

  // A rising thermal flag always leaves its sticky bit set, even against a read clear.
  property p_thermal_sticky;
    (CE && THERMAL_LEVEL > st_reg.warn_lvl && !st_reg.flags[flag_out_pkg::FLG_THERMAL])
      |=> st_reg.irq_sts[flag_out_pkg::FLG_THERMAL];
  endproperty
  a_thermal_sticky: assert property (p_thermal_sticky) else $error("thermal status bit not set"); // R7

  property p_relay_route;
    (CE && st_reg.selr == flag_out_pkg::FC_THERMAL) |=> RELAY == $past(st_reg.flags[flag_out_pkg::FLG_THERMAL]);
  endproperty
  a_relay_route: assert property (p_relay_route) else $error("relay does not carry its flag"); // R8

  property p_out12_route;
    (CE && st_reg.sel12 == flag_out_pkg::FC_TORQUE_LIMIT) |=> OUT12 == $past(st_reg.flags[flag_out_pkg::FLG_TLIM]);
  endproperty
  a_out12_route: assert property (p_out12_route) else $error("output 12 does not carry its flag"); // R8

  // The selector must still name the flag in the cycle the output is launched.
  property p_out11_path;
    CE ##1 (CE && st_reg.sel11 == flag_out_pkg::FC_LOW_SUPPLY) |=> OUT11 == $past(UNDERVOLT, 2);
  endproperty
  a_out11_path: assert property (p_out11_path) else $error("output 11 lags its flag"); // R10

  property p_unknown_code;
    (CE && st_reg.sel11 == flag_out_pkg::SEL_RST) |=> !OUT11;
  endproperty
  a_unknown_code: assert property (p_unknown_code) else $error("output 11 high for unused code"); // R10

  // Write data phases are left out because they may change the mask at that edge.
  property p_irq_raise;
    (CE && st_reg.bst != flag_out_pkg::BUS_WDATA && |(flags_now & ~st_reg.flags & st_reg.irq_mask)) |=> IRQ;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("interrupt missing");

  property p_irq_masked;
    (CE && st_reg.bst != flag_out_pkg::BUS_WDATA && !(|st_reg.irq_mask)) |=> !IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while fully masked");

  property p_ce_freeze;
    !CE |=> $stable(st_reg);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

  property p_bus_stall;
    (CE && st_reg.bst == flag_out_pkg::BUS_WDATA && accept && !HWRITE) |=> !HREADYOUT;
  endproperty
  a_bus_stall: assert property (p_bus_stall) else $error("read after write not stalled");

  property p_stall_once;
    (CE && !HREADYOUT) |=> HREADYOUT;
  endproperty
  a_stall_once: assert property (p_stall_once) else $error("stall longer than one cycle");

  c_out12_rise: cover property (CE && st_reg.sel12 == flag_out_pkg::FC_OVER_TORQUE ##2 $rose(OUT12));
  c_irq_rise: cover property ($rose(IRQ));
  c_read_wait: cover property (!HREADYOUT ##1 HREADYOUT);

endmodule

// ==== flag_out_pkg.sv ====
package flag_out_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing of the accumulated time counters.
  localparam longint unsigned CLK_PERIOD_NS = 10;
  localparam longint unsigned NS_PER_S = 1000000000;
  localparam longint unsigned TIME_UNIT_S = 3600;
  localparam logic [63:0] TIME_UNIT_CYCLES = 64'(TIME_UNIT_S * NS_PER_S / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_SEL = 8'h00;
  localparam logic [7:0] OFS_VF = 8'h04;
  localparam logic [7:0] OFS_TORQUE_THR = 8'h08;
  localparam logic [7:0] OFS_TIME_LIM = 8'h0C;
  localparam logic [7:0] OFS_WARN_LVL = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_RUN_HRS = 8'h18;
  localparam logic [7:0] OFS_PWR_HRS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // Field positions inside the selector register.
  localparam int SEL11_LSB = 0;
  localparam int SEL12_LSB = 8;
  localparam int SELR_LSB = 16;

  // Reset values.
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] VF_RST = 8'h00;
  localparam logic [15:0] TORQUE_THR_RST = 16'h0064;
  localparam logic [15:0] TIME_LIM_RST = 16'hFFFF;
  localparam logic [15:0] WARN_LVL_RST = 16'h0050;
  localparam logic [5:0] MASK_RST = 6'h00;

  // Curve selection value that enables sensorless vector mode.
  localparam logic [7:0] VF_SENSORLESS_VECTOR = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Output function codes and flag bit positions.
  localparam logic [7:0] FC_OVER_TORQUE = 8'h07;
  localparam logic [7:0] FC_LOW_SUPPLY = 8'h09;
  localparam logic [7:0] FC_TORQUE_LIMIT = 8'h0A;
  localparam logic [7:0] FC_RUN_TIME = 8'h0B;
  localparam logic [7:0] FC_POWERED_TIME = 8'h0C;
  localparam logic [7:0] FC_THERMAL = 8'h0D;
  localparam int FLG_OVER_TORQUE = 0;
  localparam int FLG_LOW = 1;
  localparam int FLG_TLIM = 2;
  localparam int FLG_RUN = 3;
  localparam int FLG_PWR = 4;
  localparam int FLG_THERMAL = 5;
  localparam int NUM_FLAGS = 6;
  localparam int NUM_OUTS = 3;

  // Register bus phase states.
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WDATA = 3'b010,
    BUS_RWAIT = 3'b100
  } bus_state_t;

  // Picks the flag level that a function code names; unknown codes give low.
  function automatic logic flag_of_code(input logic [7:0] code, input logic [NUM_FLAGS-1:0] f);
    case (code)
      FC_OVER_TORQUE: return f[FLG_OVER_TORQUE];
      FC_LOW_SUPPLY: return f[FLG_LOW];
      FC_TORQUE_LIMIT: return f[FLG_TLIM];
      FC_RUN_TIME: return f[FLG_RUN];
      FC_POWERED_TIME: return f[FLG_PWR];
      FC_THERMAL: return f[FLG_THERMAL];
      default: return 1'b0;
    endcase
  endfunction

endpackage

// ==== flag_route.sv ====
`timescale 1ns/1ps
// Routes the flag that each selector names onto its output level.
module flag_route (
  flag_sel_if.route rt
);

  genvar g;
  generate
    for (g = 0; g < flag_out_pkg::NUM_OUTS; g++) begin : g_out
      assign rt.level[g] = flag_out_pkg::flag_of_code(rt.sel[g], rt.flags);
    end
  endgenerate

endmodule

// ==== flag_sel_if.sv ====
`timescale 1ns/1ps
// Carries the flag levels and the three selectors to the router and the levels back.
interface flag_sel_if;
  logic [flag_out_pkg::NUM_FLAGS-1:0] flags;
  logic [flag_out_pkg::NUM_OUTS-1:0][7:0] sel;
  logic [flag_out_pkg::NUM_OUTS-1:0] level;
  modport src (output flags, output sel, input level);
  modport route (input flags, input sel, output level);
endinterface

// ==== hour_accum.sv ====
`timescale 1ns/1ps
// Counts whole time units while enabled and saturates at the top.
module hour_accum #(
  parameter logic [63:0] UNIT_CYCLES = flag_out_pkg::TIME_UNIT_CYCLES,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic en,
  output logic [WIDTH-1:0] units
);

  typedef struct packed {
    logic [63:0] tick;
    logic [WIDTH-1:0] units;
  } acc_t;

  acc_t acc_reg;
  acc_t acc_next;

  // Advances the sub-unit tick and carries into the unit count.
  always_comb begin
    acc_next = acc_reg;
    if (ce && en) begin
      if (acc_reg.tick >= UNIT_CYCLES - 64'h1) begin
        acc_next.tick = 64'h0;
        if (acc_reg.units != {WIDTH{1'b1}}) begin
          acc_next.units = acc_reg.units + 1'b1;
        end
      end else begin
        acc_next.tick = acc_reg.tick + 64'h1;
      end
    end
  end

  // Registers the counter state.
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign units = acc_reg.units;

endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the status flag outputs and their register bus.
module tb_top;
  logic ref_clk, sys_rst, ce, hsel, hwrite, undervolt, torque_limiting, motor_running, arrival;
  logic hreadyout, hresp, out11, out12, relay, irq, braking;
  logic [31:0] haddr, hwdata, hrdata, rd, r, ew, h;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] torque_est, thermal_level, tq, th;
  logic [7:0] vf;
  logic [5:0] f;
  logic [31:0] seed;
  int error_cnt, checked;
  logic [7:0] codes [8] = '{8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h00, 8'hFF};
  logic [7:0] rofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24, 8'h30};
  logic [31:0] rval [7] = '{32'h0, 32'h0, 32'h64, 32'hFFFF, 32'h50, 32'h0, 32'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Device with a short time unit so the counters move within the run.
  drive_status_flag_outputs #(.TIME_UNIT_CYCLES(64'hA), .LEVEL_W(16)) dut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TORQUE_EST(torque_est), .UNDERVOLT(undervolt),
    .TORQUE_LIMITING(torque_limiting), .MOTOR_RUNNING(motor_running), .THERMAL_LEVEL(thermal_level),
    .OUT11(out11), .OUT12(out12), .RELAY(relay), .IRQ(irq)
  );

  // Brake sequencer watching output 11.
  brake_seq_model partner (.clk(ref_clk), .rst(sys_rst), .arrival(arrival), .over_torque(out11),
    .braking(braking));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Repeatable xorshift source.
  function automatic logic [31:0] next_rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected flag vector with default thresholds and time counters below the limit.
  function automatic logic [5:0] exp_flags(input logic [7:0] v, input logic [15:0] t, input logic [15:0] w,
    input logic u, input logic l);
    return {w > 16'h0050, 1'b0, 1'b0, l, u, (v == 8'h03) && (t > 16'h0064)};
  endfunction

  // Level that an output takes for a selector code.
  function automatic logic code_level(input logic [7:0] c, input logic [5:0] fl);
    case (c)
      8'h07: return fl[0];
      8'h09: return fl[1];
      8'h0A: return fl[2];
      8'h0B: return fl[3];
      8'h0C: return fl[4];
      8'h0D: return fl[5];
      default: return 1'b0;
    endcase
  endfunction

  // Single-bit comparison.
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // Word comparison.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h", $time, msg, got);
    end
  endtask

  // One transfer; each phase stands until ready is seen high at a rising edge, the watchdog ends a hang.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    q = hrdata;
    chk_bit(hresp, 1'b0, "bus response");
  endtask

  // Write whose data phase carries a read of the same word; the read is stalled once.
  task automatic wr_then_rd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= wd;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    do begin @(posedge ref_clk); end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    sys_rst = 1'b1; ce = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; torque_est = 16'h0; thermal_level = 16'h0; undervolt = 1'b0;
    torque_limiting = 1'b0; motor_running = 1'b0; arrival = 1'b0; seed = 32'd40335;
    error_cnt = 0; checked = 0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, then an ignored write to an unmapped place.
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, rofs[i], 32'h0, rd);
      chk_word(rd, rval[i], "reset value");
    end
    bus(1'b1, 8'h30, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h30, 32'h0, rd);
    chk_word(rd, 32'h0, "unmapped read");
    wr_then_rd(8'h00, 32'hFF0D0B09, rd);
    chk_word(rd, 32'h000D0B09, "stalled read");
    $display("test reset done");
    // Every code on every output, random levels, equality at the thresholds first.
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        r = next_rnd();
        vf = r[0] ? 8'h03 : 8'h00;
        tq = (k == 0) ? 16'h0064 : {8'h0, r[15:8]};
        th = (k == 0) ? 16'h0050 : {8'h0, r[23:16]};
        bus(1'b1, 8'h04, {24'h0, vf}, rd);
        bus(1'b1, 8'h00, {8'h0, codes[(i + 2) % 8], codes[(i + 1) % 8], codes[i]}, rd);
        torque_est <= tq;
        thermal_level <= th;
        undervolt <= r[24];
        torque_limiting <= r[25];
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        f = exp_flags(vf, tq, th, r[24], r[25]);
        ew = {21'h0, code_level(codes[(i + 2) % 8], f), code_level(codes[(i + 1) % 8], f),
          code_level(codes[i], f), 2'b00, f};
        chk_bit(out11, ew[8], "out11 level");
        chk_bit(out12, ew[9], "out12 level");
        chk_bit(relay, ew[10], "relay level");
        @(posedge ref_clk);
        bus(1'b0, 8'h14, 32'h0, rd);
        chk_word(rd & 32'h0000073F, ew, "flag register");
      end
    end
    $display("test routing done");
    // Lift brake: arrival starts braking, over-torque on output 11 ends it.
    bus(1'b1, 8'h04, 32'h3, rd);
    bus(1'b1, 8'h00, 32'h7, rd);
    torque_est <= 16'h0;
    repeat (3) @(posedge ref_clk);
    arrival <= 1'b1;
    @(posedge ref_clk);
    arrival <= 1'b0;
    @(negedge ref_clk);
    chk_bit(braking, 1'b1, "braking start");
    @(posedge ref_clk);
    torque_est <= 16'h00C8;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(braking, 1'b0, "braking end");
    @(posedge ref_clk);
    $display("test brake done");
    // Run and powered time against a limit of five units.
    bus(1'b1, 8'h0C, 32'h5, rd);
    for (int j = 0; j < 2; j++) begin
      motor_running <= 1'b1;
      repeat (40) @(posedge ref_clk);
      motor_running <= 1'b0;
      repeat (3) @(posedge ref_clk);
      bus(1'b0, 8'h18, 32'h0, h);
      bus(1'b0, 8'h14, 32'h0, rd);
      chk_bit(rd[3], h > 32'h5, "run flag vs count");
      chk_bit(rd[3], j == 1, "run flag");
      chk_bit(rd[4], 1'b1, "powered flag");
    end
    bus(1'b0, 8'h1C, 32'h0, h);
    chk_bit(h > 32'h5, 1'b1, "powered count");
    $display("test time done");
    // Interrupt raised by thermal warning, cleared by read, masked for low supply.
    thermal_level <= 16'h0;
    undervolt <= 1'b0;
    bus(1'b1, 8'h24, 32'h20, rd);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, 8'h20, 32'h0, rd);
    @(negedge ref_clk);
    chk_bit(irq, 1'b0, "irq idle");
    @(posedge ref_clk);
    thermal_level <= 16'h00C8;
    undervolt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(irq, 1'b1, "irq raised");
    @(posedge ref_clk);
    bus(1'b0, 8'h20, 32'h0, rd);
    chk_word(rd & 32'h3F, 32'h22, "irq status");
    repeat (2) @(posedge ref_clk);
    undervolt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    undervolt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(irq, 1'b0, "irq masked");
    @(posedge ref_clk);
    $display("test irq done");
    // Clock enable low freezes the routed output while its flag changes.
    bus(1'b1, 8'h00, 32'h9, rd);
    repeat (2) @(posedge ref_clk);
    ce <= 1'b0;
    undervolt <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(out11, 1'b1, "frozen output");
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit(out11, 1'b0, "output after enable");
    @(posedge ref_clk);
    $display("test enable done");
    finish_test();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end
endmodule
